// >>> logic/smra_pkg.sv
package smra_pkg;

  // ==========================================================
  // command codes and address space
  localparam logic [7:0] CMD_BLK_WRITE  = 8'hF0;
  localparam logic [7:0] CMD_BLK_RDCALL = 8'hF1;
  localparam logic [7:0] REG_SPACE_LAST = 8'hEF;
  localparam logic [7:0] ADDR_LAST      = 8'hFF;
  localparam logic [7:0] ADDR_STEP      = 8'h01;

  // ==========================================================
  // byte framing inside a write phase
  localparam logic [3:0] BYTE_BITS  = 4'h8;
  localparam logic [3:0] BIT_STEP   = 4'h1;
  localparam logic [2:0] IDX_CMD    = 3'h0;
  localparam logic [2:0] IDX_START  = 3'h2;
  localparam logic [2:0] IDX_RDCNT  = 3'h3;
  localparam logic [2:0] IDX_MAX    = 3'h4;
  localparam logic [2:0] IDX_STEP   = 3'h1;

  // ==========================================================
  // messages from the link side to the system side
  localparam int         MSG_W      = 18;
  localparam logic [1:0] MSG_WR     = 2'h1;
  localparam logic [1:0] MSG_RDREQ  = 2'h2;
  localparam logic [1:0] MSG_RDDONE = 2'h3;

  // ==========================================================
  // timing
  localparam int LINK_PERIOD_NS      = 64;
  localparam int TIMEOUT_NS_DEFAULT  = 25_000_000;

  // ==========================================================
  // state and transaction mode
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_ACK  = 6'h04,
    ST_WRX  = 6'h08,
    ST_TX   = 6'h10,
    ST_MACK = 6'h20
  } smra_state_t;

  typedef enum logic [2:0] {
    MODE_PLAIN  = 3'h1,
    MODE_BLKW   = 3'h2,
    MODE_RDCALL = 3'h4
  } smra_mode_t;

endpackage

// >>> logic/smra_sync.sv
`timescale 1ns/10ps
module smra_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  // ==========================================================
  // two-stage synchroniser, first stage feeds only the second
  logic [W-1:0] meta_r;

  always_ff @(posedge clk) begin
    meta_r <= d;
    q      <= meta_r;
  end
endmodule // smra_sync

// >>> logic/smra_xfer.sv
`timescale 1ns/10ps
module smra_xfer #(
  parameter int W = 8
) (
  input  wire logic         src_clk,
  input  wire logic         src_rst,
  input  wire logic         src_ce,
  input  wire logic         src_send,
  input  wire logic [W-1:0] src_word,
  input  wire logic         dst_clk,
  input  wire logic         dst_rst,
  input  wire logic         dst_ce,
  output logic              dst_valid,
  output logic      [W-1:0] dst_word
);
  // ==========================================================
  // toggle crossing; no ack, so sends must be spaced by
  // several destination cycles (the byte rate guarantees it)
  logic         tog_r;
  logic [W-1:0] hold_r;
  logic         tog_s;
  logic         tog_d_r;

  always_ff @(posedge src_clk) begin
    if (src_rst) begin
      tog_r  <= 1'b0;
      hold_r <= '0;
    end else if (src_ce && src_send) begin
      tog_r  <= ~tog_r;
      hold_r <= src_word;
    end
  end

  smra_sync #(.W(1)) u_tog_sync (
    .clk (dst_clk),
    .d   (tog_r),
    .q   (tog_s)
  );

  // hold_r is stable long before the toggle edge is seen here
  always_ff @(posedge dst_clk) begin
    if (dst_rst) begin
      tog_d_r   <= 1'b0;
      dst_valid <= 1'b0;
      dst_word  <= '0;
    end else if (dst_ce) begin
      tog_d_r   <= tog_s;
      dst_valid <= tog_s ^ tog_d_r;
      if (tog_s ^ tog_d_r) begin
        dst_word <= hold_r;
      end
    end
  end
endmodule // smra_xfer

// >>> logic/smra_slave.sv
`timescale 1ns/10ps
// How it works
// R1 - address seven bits msb first, then direction
// R2 - acknowledge every written byte until stop
// R3 - word write: address, low byte, high byte
// R4 - command F0 starts a block write
// R5 - block write: first data byte is address
// R6 - block write byte count is ignored
// R7 - no block length limit on writes
// R8 - writes beyond EF acknowledged but dropped
// R9 - write address saturates at FF
// R10 - plain block write: address then data bytes
// R11 - byte read: address write, restart, one byte
// R12 - word read: low byte then high byte
// R13 - F1 call: count, start, read count
// R14 - call read returns count then data
// R15 - reads beyond EF return 00
// R16 - read address never wraps past FF
// R17 - keep sending while master acknowledges
// R18 - release data line after master nack
// R19 - register space is 00 through EF
// R20 - base address not advanced by reads
// R21 - long low line returns engine idle
// R22 - partial bytes at start/stop have no effect
// R23 - pointer advances one per block byte
// R24 - read uses address from write phase
module smra_slave
  import smra_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = 7'h2E,
  parameter int         TIMEOUT_NS = TIMEOUT_NS_DEFAULT
) (
  input  wire logic       CLK_SYS,
  input  wire logic       RST,
  input  wire logic       CLK_EN,
  input  wire logic       LINK_SAMPLE_CLK,
  input  wire logic       SERIAL_BUS_CLOCK_PIN,
  input  wire logic       SERIAL_BUS_DATA_PIN_I,
  output logic            SERIAL_BUS_DATA_PIN_O,
  output logic            SERIAL_BUS_DATA_PIN_OE,
  output logic            REG_WR_EN,
  output logic      [7:0] REG_WR_ADDR,
  output logic      [7:0] REG_WR_DATA,
  output logic            REG_RD_REQ,
  output logic      [7:0] REG_RD_ADDR,
  input  wire logic [7:0] REG_RD_DATA,
  output logic            REG_RD_DONE
);

  // ==========================================================
  // timeout count
  localparam int TO_RAW    = TIMEOUT_NS / LINK_PERIOD_NS;
  localparam int TO_CYCLES = (TO_RAW < 1) ? 1 : TO_RAW;
  localparam int TO_W      = $clog2(TO_CYCLES + 1);
  localparam logic [TO_W-1:0] TO_MAX = TO_W'(TO_CYCLES);
  localparam logic [TO_W-1:0] TO_ONE = TO_W'(1);

  function automatic logic in_space(input logic [7:0] a);
    in_space = (a <= REG_SPACE_LAST); // see R19
  endfunction

  function automatic logic [7:0] sat_inc(input logic [7:0] a);
    sat_inc = (a == ADDR_LAST) ? a : a + ADDR_STEP; // see R9 // see R16
  endfunction

  function automatic logic [7:0] tx_pick(input logic       cnt,
                                         input logic [7:0] n,
                                         input logic [7:0] a,
                                         input logic [7:0] d);
    if (cnt) begin
      tx_pick = n; // see R14
    end else if (in_space(a)) begin
      tx_pick = d;
    end else begin
      tx_pick = 8'h00; // see R15
    end
  endfunction

  // ==========================================================
  // pin and control synchronisers into the link domain
  logic [3:0] pin_s;
  logic       rst_l;
  logic       ce_l;
  logic       scl_s;
  logic       sda_s;

  smra_sync #(.W(4)) u_pin_sync (
    .clk (LINK_SAMPLE_CLK),
    .d   ({RST, CLK_EN, SERIAL_BUS_CLOCK_PIN, SERIAL_BUS_DATA_PIN_I}),
    .q   (pin_s)
  );

  assign rst_l = pin_s[3];
  assign ce_l  = pin_s[2];
  assign scl_s = pin_s[1];
  assign sda_s = pin_s[0];

  logic scl_d_r;
  logic sda_d_r;

  always_ff @(posedge LINK_SAMPLE_CLK) begin
    if (rst_l) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else if (ce_l) begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic scl_fall;

  assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;
  assign scl_rise  = scl_s & ~scl_d_r;
  assign scl_fall  = ~scl_s & scl_d_r;

  // ==========================================================
  // stuck-low timeout
  logic [TO_W-1:0] to_cnt_r;
  logic            to_hit_r;

  always_ff @(posedge LINK_SAMPLE_CLK) begin
    if (rst_l) begin
      to_cnt_r <= '0;
      to_hit_r <= 1'b0;
    end else if (ce_l) begin
      if (scl_s && sda_s) begin
        to_cnt_r <= '0;
      end else if (to_cnt_r != TO_MAX) begin
        to_cnt_r <= to_cnt_r + TO_ONE;
      end
      to_hit_r <= (to_cnt_r == TO_MAX); // see R21
    end
  end

  // ==========================================================
  // read data returned from the system side
  logic       ret_valid;
  logic [7:0] ret_word;
  logic [7:0] rd_data_r;

  always_ff @(posedge LINK_SAMPLE_CLK) begin
    if (rst_l) begin
      rd_data_r <= 8'h00;
    end else if (ce_l && ret_valid) begin
      rd_data_r <= ret_word;
    end
  end

  // ==========================================================
  // transaction engine
  smra_state_t state_r;
  smra_mode_t  mode_r;
  logic [3:0]  bit_cnt_r;
  logic [7:0]  shift_r;
  logic [2:0]  byte_idx_r;
  logic [7:0]  ptr_r;
  logic [7:0]  base_r;
  logic [7:0]  rd_cnt_r;
  logic        rw_r;
  logic        ack_clk_r;
  logic        call_pend_r;
  logic        cnt_phase_r;
  logic        sda_oe_r;
  logic        msg_send_r;
  logic [MSG_W-1:0] msg_word_r;
  logic [7:0]  tx_next;

  assign tx_next = tx_pick(cnt_phase_r, rd_cnt_r, ptr_r, rd_data_r);

  always_ff @(posedge LINK_SAMPLE_CLK) begin
    if (rst_l) begin
      state_r     <= ST_IDLE;
      mode_r      <= MODE_PLAIN;
      bit_cnt_r   <= 4'h0;
      shift_r     <= 8'h00;
      byte_idx_r  <= IDX_CMD;
      ptr_r       <= 8'h00;
      base_r      <= 8'h00;
      rd_cnt_r    <= 8'h00;
      rw_r        <= 1'b0;
      ack_clk_r   <= 1'b0;
      call_pend_r <= 1'b0;
      cnt_phase_r <= 1'b0;
      sda_oe_r    <= 1'b0;
      msg_send_r  <= 1'b0;
      msg_word_r  <= '0;
    end else if (ce_l) begin
      msg_send_r <= 1'b0;
      if (to_hit_r) begin
        state_r     <= ST_IDLE; // see R21
        sda_oe_r    <= 1'b0;
        call_pend_r <= 1'b0;
      end else if (start_det) begin
        // nothing is committed before a byte ends, so a cut byte is lost
        state_r    <= ST_ADDR; // see R22
        bit_cnt_r  <= 4'h0;
        ack_clk_r  <= 1'b0;
        sda_oe_r   <= 1'b0;
        byte_idx_r <= IDX_CMD;
      end else if (stop_det) begin
        state_r     <= ST_IDLE; // see R22
        sda_oe_r    <= 1'b0;
        call_pend_r <= 1'b0;
      end else begin
        case (state_r)
          ST_ADDR, ST_WRX: begin
            if (scl_rise) begin
              shift_r   <= {shift_r[6:0], sda_s}; // see R1
              bit_cnt_r <= bit_cnt_r + BIT_STEP;
            end else if (scl_fall && bit_cnt_r == BYTE_BITS) begin
              bit_cnt_r <= 4'h0;
              if (state_r == ST_ADDR) begin
                if (shift_r[7:1] == SLAVE_ADDR) begin // see R1
                  state_r  <= ST_ACK;
                  sda_oe_r <= 1'b1;
                  rw_r     <= shift_r[0];
                  if (shift_r[0]) begin
                    ptr_r       <= base_r; // see R24 // see R11
                    cnt_phase_r <= call_pend_r; // see R14
                    msg_send_r  <= 1'b1;
                    msg_word_r  <= {MSG_RDREQ, base_r, 8'h00};
                  end
                end else begin
                  state_r <= ST_IDLE;
                end
              end else begin
                state_r  <= ST_ACK;
                sda_oe_r <= 1'b1; // see R2 // see R7
                if (byte_idx_r != IDX_MAX) begin
                  byte_idx_r <= byte_idx_r + IDX_STEP;
                end
                if (byte_idx_r == IDX_CMD) begin
                  call_pend_r <= 1'b0;
                  if (shift_r == CMD_BLK_WRITE) begin
                    mode_r <= MODE_BLKW; // see R4
                  end else if (shift_r == CMD_BLK_RDCALL) begin
                    mode_r <= MODE_RDCALL; // see R13
                  end else begin
                    mode_r <= MODE_PLAIN;
                    ptr_r  <= shift_r; // see R10 // see R3
                    base_r <= shift_r;
                  end
                end else if (mode_r == MODE_PLAIN ||
                             (mode_r == MODE_BLKW && byte_idx_r > IDX_START)) begin
                  if (in_space(ptr_r)) begin
                    msg_send_r <= 1'b1; // see R8
                    msg_word_r <= {MSG_WR, ptr_r, shift_r};
                  end
                  ptr_r <= sat_inc(ptr_r); // see R9 // see R23
                end else if (byte_idx_r == IDX_START) begin
                  ptr_r  <= shift_r; // see R5 // see R6
                  base_r <= shift_r;
                end else if (mode_r == MODE_RDCALL && byte_idx_r == IDX_RDCNT) begin
                  rd_cnt_r    <= shift_r; // see R13
                  call_pend_r <= 1'b1;
                end
              end
            end
          end
          ST_ACK: begin
            if (scl_rise) begin
              ack_clk_r <= 1'b1;
            end else if (scl_fall && ack_clk_r) begin
              ack_clk_r <= 1'b0;
              bit_cnt_r <= 4'h0;
              if (rw_r) begin
                state_r  <= ST_TX;
                shift_r  <= tx_next;
                sda_oe_r <= ~tx_next[7];
              end else begin
                state_r  <= ST_WRX;
                sda_oe_r <= 1'b0;
              end
            end
          end
          ST_TX: begin
            if (scl_rise) begin
              bit_cnt_r <= bit_cnt_r + BIT_STEP;
            end else if (scl_fall) begin
              if (bit_cnt_r == BYTE_BITS) begin
                state_r   <= ST_MACK;
                sda_oe_r  <= 1'b0;
                bit_cnt_r <= 4'h0;
                if (cnt_phase_r) begin
                  cnt_phase_r <= 1'b0;
                  call_pend_r <= 1'b0;
                end else begin
                  // clear-on-read side effects only after a whole byte
                  msg_send_r <= 1'b1; // see R22
                  msg_word_r <= {MSG_RDDONE, ptr_r, 8'h00};
                  ptr_r      <= sat_inc(ptr_r); // see R12 // see R16 // see R20
                end
              end else begin
                shift_r  <= {shift_r[6:0], 1'b0};
                sda_oe_r <= ~shift_r[6];
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              if (sda_s) begin
                state_r <= ST_IDLE; // see R18
              end else begin
                ack_clk_r  <= 1'b1; // see R17
                msg_send_r <= 1'b1;
                msg_word_r <= {MSG_RDREQ, ptr_r, 8'h00};
              end
            end else if (scl_fall && ack_clk_r) begin
              ack_clk_r <= 1'b0;
              state_r   <= ST_TX;
              shift_r   <= tx_next;
              sda_oe_r  <= ~tx_next[7];
            end
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end

  always_ff @(posedge LINK_SAMPLE_CLK) begin
    if (rst_l) begin
      SERIAL_BUS_DATA_PIN_OE <= 1'b0;
      SERIAL_BUS_DATA_PIN_O  <= 1'b0;
    end else if (ce_l) begin
      SERIAL_BUS_DATA_PIN_OE <= sda_oe_r;
      SERIAL_BUS_DATA_PIN_O  <= 1'b0;
    end
  end

  // ==========================================================
  // crossings between the link and system domains
  logic             msg_valid;
  logic [MSG_W-1:0] msg_word;
  logic             ret_send_r;
  logic [7:0]       ret_data_r;

  smra_xfer #(.W(MSG_W)) u_msg_xfer (
    .src_clk   (LINK_SAMPLE_CLK),
    .src_rst   (rst_l),
    .src_ce    (ce_l),
    .src_send  (msg_send_r),
    .src_word  (msg_word_r),
    .dst_clk   (CLK_SYS),
    .dst_rst   (RST),
    .dst_ce    (CLK_EN),
    .dst_valid (msg_valid),
    .dst_word  (msg_word)
  );

  smra_xfer #(.W(8)) u_ret_xfer (
    .src_clk   (CLK_SYS),
    .src_rst   (RST),
    .src_ce    (CLK_EN),
    .src_send  (ret_send_r),
    .src_word  (ret_data_r),
    .dst_clk   (LINK_SAMPLE_CLK),
    .dst_rst   (rst_l),
    .dst_ce    (ce_l),
    .dst_valid (ret_valid),
    .dst_word  (ret_word)
  );

  // ==========================================================
  // system-side register port
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      REG_WR_EN   <= 1'b0;
      REG_WR_ADDR <= 8'h00;
      REG_WR_DATA <= 8'h00;
      REG_RD_REQ  <= 1'b0;
      REG_RD_ADDR <= 8'h00;
      REG_RD_DONE <= 1'b0;
      ret_send_r  <= 1'b0;
      ret_data_r  <= 8'h00;
    end else if (CLK_EN) begin
      REG_WR_EN   <= 1'b0;
      REG_RD_REQ  <= 1'b0;
      REG_RD_DONE <= 1'b0;
      ret_send_r  <= REG_RD_REQ;
      if (REG_RD_REQ) begin
        ret_data_r <= REG_RD_DATA;
      end
      if (msg_valid) begin
        if (msg_word[17:16] == MSG_WR) begin
          REG_WR_EN   <= 1'b1;
          REG_WR_ADDR <= msg_word[15:8];
          REG_WR_DATA <= msg_word[7:0];
        end else if (msg_word[17:16] == MSG_RDREQ) begin
          REG_RD_REQ  <= 1'b1;
          REG_RD_ADDR <= msg_word[15:8];
        end else if (msg_word[17:16] == MSG_RDDONE) begin
          REG_RD_DONE <= 1'b1;
          REG_RD_ADDR <= msg_word[15:8];
        end
      end
    end
  end

endmodule // smra_slave

// >>> testbench/smra_host.sv
`timescale 1ns/10ps
// ==========
// bus master model, open drain data, clock idles high
module smra_host #(
  parameter int T = 512
) (
  output logic          scl,
  output logic          sda_low,
  input  wire logic     sda
);
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  // data only moves mid-low, so no false start or stop
  task automatic xbit(input logic b, output logic r);
    #(T/2) sda_low = ~b;
    #(T/2) scl = 1'b1;
    #T r = sda;
    scl = 1'b0;
  endtask

  // also serves as repeated start
  task automatic start;
    #(T/2) sda_low = 1'b0;
    #(T/2) scl = 1'b1;
    #T sda_low = 1'b1;
    #T scl = 1'b0;
  endtask

  task automatic stop;
    #(T/2) sda_low = 1'b1;
    #(T/2) scl = 1'b1;
    #T sda_low = 1'b0;
    #T;
  endtask

  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) xbit(d[i], r);
    xbit(1'b1, r);
    ack = ~r;
  endtask

  task automatic rbyte(output logic [7:0] d, input logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) xbit(1'b1, d[i]);
    xbit(~ack, r);
  endtask
endmodule // smra_host

// >>> testbench/smra_slave_assertions.sv
`timescale 1ns/10ps
module smra_slave_assertions
  import smra_pkg::*;
(
  input wire logic       CLK_SYS,
  input wire logic       RST,
  input wire logic       LINK_SAMPLE_CLK,
  input wire logic       SERIAL_BUS_CLOCK_PIN,
  input wire logic       SERIAL_BUS_DATA_PIN_O,
  input wire logic       SERIAL_BUS_DATA_PIN_OE,
  input wire logic       REG_WR_EN,
  input wire logic [7:0] REG_WR_ADDR,
  input wire logic [7:0] REG_WR_DATA,
  input wire logic       REG_RD_REQ,
  input wire logic       REG_RD_DONE
);
  // ==========
  // helpers
  logic       scl_d_r;
  logic [3:0] fall_cnt_r;
  logic       req_seen_r;

  // link cycles since bus clock fell, saturating
  always_ff @(posedge LINK_SAMPLE_CLK) begin
    scl_d_r <= SERIAL_BUS_CLOCK_PIN;
    if (RST) fall_cnt_r <= 4'hF;
    else if (scl_d_r && !SERIAL_BUS_CLOCK_PIN) fall_cnt_r <= 4'h0;
    else if (fall_cnt_r != 4'hF) fall_cnt_r <= fall_cnt_r + 4'h1;
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) req_seen_r <= 1'b0;
    else if (REG_RD_REQ) req_seen_r <= 1'b1;
    else if (REG_RD_DONE) req_seen_r <= 1'b0;
  end

  // ==========
  // assertions
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  a_wr_in_space: assert property (REG_WR_EN |-> REG_WR_ADDR <= REG_SPACE_LAST)
    else $error("write strobe outside register space");
  a_wr_one_pulse: assert property (REG_WR_EN |=> !REG_WR_EN [*8])
    else $error("write strobe too long or too close");
  a_wr_value_hold: assert property (REG_WR_EN |=>
    ($stable(REG_WR_ADDR) && $stable(REG_WR_DATA)) [*8])
    else $error("write address or data moved early");
  a_rd_one_pulse: assert property (REG_RD_REQ |=> !REG_RD_REQ [*8])
    else $error("read request too long or too close");
  a_done_one_pulse: assert property (REG_RD_DONE |=> !REG_RD_DONE [*8])
    else $error("read done too long or too close");
  a_done_after_req: assert property (REG_RD_DONE |-> req_seen_r)
    else $error("read done without a request");
  a_oe_open_drain: assert property (@(posedge LINK_SAMPLE_CLK) disable iff (RST)
    SERIAL_BUS_DATA_PIN_OE |-> !SERIAL_BUS_DATA_PIN_O)
    else $error("data pin driven high");
  // data line may only move in the clock low phase
  a_oe_after_fall: assert property (@(posedge LINK_SAMPLE_CLK) disable iff (RST)
    $changed(SERIAL_BUS_DATA_PIN_OE) |-> fall_cnt_r inside {[4'h2:4'h6]})
    else $error("data enable moved outside its slot");

  c_write: cover property (REG_WR_EN);
  c_read_done: cover property (REG_RD_DONE);
  c_ack: cover property (@(posedge LINK_SAMPLE_CLK) $rose(SERIAL_BUS_DATA_PIN_OE));
endmodule // smra_slave_assertions

// >>> testbench/smra_slave_tb.sv
`timescale 1ns/10ps
module smra_slave_tb;
  import smra_pkg::*;
  localparam logic [6:0] SA = 7'h2E;
  logic       clk_sys = 1'b0;
  logic       clk_link = 1'b0;
  logic       rst = 1'b1;
  logic       scl, h_low, sda, oe, o, wr_en, rd_req, rd_done;
  logic [7:0] wr_addr, wr_data, rd_addr;
  logic [7:0] rd_data = 8'h00;
  logic [7:0] mem [256];
  int         error_cnt = 0;
  int         checks_done = 0;
  int         wr_cnt = 0;
  int         done_cnt = 0;

  always #2 clk_sys = ~clk_sys;
  initial begin
    #13;
    forever #32 clk_link = ~clk_link;
  end
  // pull-up wire, unknown enable taken as released
  assign sda = ~(h_low | (oe === 1'b1 && o === 1'b0));

  smra_slave #(.SLAVE_ADDR(SA), .TIMEOUT_NS(32_000)) DUT (
    .CLK_SYS(clk_sys), .RST(rst), .CLK_EN(1'b1), .LINK_SAMPLE_CLK(clk_link),
    .SERIAL_BUS_CLOCK_PIN(scl), .SERIAL_BUS_DATA_PIN_I(sda),
    .SERIAL_BUS_DATA_PIN_O(o), .SERIAL_BUS_DATA_PIN_OE(oe),
    .REG_WR_EN(wr_en), .REG_WR_ADDR(wr_addr), .REG_WR_DATA(wr_data),
    .REG_RD_REQ(rd_req), .REG_RD_ADDR(rd_addr), .REG_RD_DATA(rd_data),
    .REG_RD_DONE(rd_done));
  smra_host u_host (.scl(scl), .sda_low(h_low), .sda(sda));

  // ==========
  // register space model
  always @(negedge clk_sys) rd_data <= mem[rd_addr];
  always @(posedge clk_sys) begin
    if (rd_done) done_cnt <= done_cnt + 1;
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
      wr_cnt <= wr_cnt + 1;
    end
  end

  // ==========
  // helpers
  function automatic logic [7:0] init_val(input logic [7:0] a);
    return a ^ 8'h5A;
  endfunction
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wb(input logic [7:0] b, input logic exp_ack);
    logic a;
    u_host.wbyte(b, a);
    chk("ack", {7'h00, exp_ack}, {7'h00, a});
  endtask
  task automatic rb(input logic [7:0] exp, input logic ack);
    logic [7:0] d;
    u_host.rbyte(d, ack);
    chk("rdata", exp, d);
  endtask
  task automatic aw(input logic rd);
    u_host.start;
    wb({SA, rd}, 1'b1);
  endtask
  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ==========
  // scenarios
  task automatic t_word_write;
    aw(1'b0);
    wb(8'h10, 1'b1);
    wb(8'hA5, 1'b1);
    wb(8'h5A, 1'b1);
    u_host.stop;
    chk("mem10", 8'hA5, mem[8'h10]);
    chk("mem11", 8'h5A, mem[8'h11]);
  endtask
  // count says one, three data bytes follow, last one out of space
  task automatic t_blk_write;
    int n0;
    n0 = wr_cnt;
    aw(1'b0);
    wb(CMD_BLK_WRITE, 1'b1);
    wb(8'h01, 1'b1);
    wb(8'hEE, 1'b1);
    wb(8'h11, 1'b1);
    wb(8'h22, 1'b1);
    wb(8'h33, 1'b1);
    u_host.stop;
    chk("memEE", 8'h11, mem[8'hEE]);
    chk("memEF", 8'h22, mem[8'hEF]);
    chk("wr_cnt", 8'h02, 8'(wr_cnt - n0));
  endtask
  task automatic t_plain_blk_write;
    int n0;
    n0 = wr_cnt;
    aw(1'b0);
    wb(8'hFE, 1'b1);
    wb(8'h44, 1'b1);
    wb(8'h55, 1'b1);
    wb(8'h66, 1'b1);
    u_host.stop;
    chk("mem00", init_val(8'h00), mem[8'h00]);
    chk("wr_cnt", 8'h00, 8'(wr_cnt - n0));
  endtask
  task automatic t_read_byte;
    int n0;
    n0 = done_cnt;
    aw(1'b0);
    wb(8'h10, 1'b1);
    aw(1'b1);
    rb(8'hA5, 1'b0);
    u_host.stop;
    aw(1'b1);
    rb(8'hA5, 1'b0);
    u_host.stop;
    chk("done_cnt", 8'h02, 8'(done_cnt - n0));
  endtask
  task automatic t_word_read;
    aw(1'b0);
    wb(8'hEF, 1'b1);
    aw(1'b1);
    rb(8'h22, 1'b1);
    rb(8'h00, 1'b0);
    u_host.stop;
  endtask
  // count of one, master keeps acking past it near the top
  task automatic t_call;
    int n0;
    n0 = done_cnt;
    aw(1'b0);
    wb(CMD_BLK_RDCALL, 1'b1);
    wb(8'h02, 1'b1);
    wb(8'hFE, 1'b1);
    wb(8'h01, 1'b1);
    aw(1'b1);
    rb(8'h01, 1'b1);
    rb(8'h00, 1'b1);
    rb(8'h00, 1'b1);
    rb(8'h00, 1'b0);
    // give the device time to take the line if it wrongly went on
    #400;
    chk("oe", 8'h00, {7'h00, oe});
    chk("done_cnt", 8'h03, 8'(done_cnt - n0));
    u_host.stop;
  endtask
  task automatic t_mismatch;
    u_host.start;
    wb({SA ^ 7'h01, 1'b0}, 1'b0);
    u_host.stop;
  endtask
  // clock held low past the limit, then a byte with no new start
  task automatic t_timeout;
    int n0;
    n0 = wr_cnt;
    aw(1'b0);
    wb(8'h21, 1'b1);
    #36_000;
    wb(8'h77, 1'b0);
    u_host.stop;
    chk("mem21", init_val(8'h21), mem[8'h21]);
    chk("wr_cnt", 8'h00, 8'(wr_cnt - n0));
  endtask

  initial begin
    for (int i = 0; i < 256; i++) mem[i] = init_val(8'(i));
    repeat (12) @(posedge clk_link);
    @(negedge clk_sys);
    rst = 1'b0;
    repeat (10) @(posedge clk_link);
    @(negedge clk_sys);
    t_word_write;
    t_blk_write;
    t_plain_blk_write;
    t_read_byte;
    t_word_read;
    t_call;
    t_mismatch;
    t_timeout;
    end_sim;
  end
  // whole run is bounded
  initial begin
    #500_000;
    error_cnt++;
    $display("MISMATCH run_time expected done seen timeout");
    end_sim;
  end
endmodule // smra_slave_tb

bind smra_slave smra_slave_assertions u_chk (
  .CLK_SYS(CLK_SYS), .RST(RST), .LINK_SAMPLE_CLK(LINK_SAMPLE_CLK),
  .SERIAL_BUS_CLOCK_PIN(SERIAL_BUS_CLOCK_PIN), .SERIAL_BUS_DATA_PIN_O(SERIAL_BUS_DATA_PIN_O),
  .SERIAL_BUS_DATA_PIN_OE(SERIAL_BUS_DATA_PIN_OE), .REG_WR_EN(REG_WR_EN),
  .REG_WR_ADDR(REG_WR_ADDR), .REG_WR_DATA(REG_WR_DATA), .REG_RD_REQ(REG_RD_REQ),
  .REG_RD_DONE(REG_RD_DONE));
